// ---- phy_mgmt_defs.svh ----
// Purpose: Offsets, field positions, reset values and counts of the PHY management block.
// Assumes: Included by its bare name before the package and the design module.
// Notes: Contract
`ifndef PHY_MGMT_DEFS_SVH
`define PHY_MGMT_DEFS_SVH
`define REG_BASIC_CONTROL 5'h00
`define REG_BASIC_STATUS 5'h01
`define REG_ADVERT 5'h04
`define REG_PARTNER 5'h05
`define REG_EXPANSION 5'h06
`define REG_NP_TX 5'h07
`define REG_IND_CTRL 5'h0d
`define REG_IND_DATA 5'h0e
`define EXT_CLK_OUT_CFG 16'h0170
`define STD_SPACE_TOP 16'h001f
`define RST_BASIC_CONTROL 16'h1140
`define RST_ADVERT 16'h01e1
`define RST_NP_TX 16'h2001
`define RST_CLK_OUT_CFG 16'h0c10
`define CLK_OUT_DIS_BIT 6
`define BC_RESET_BIT 15
`define BC_AN_EN_BIT 12
`define BC_RESTART_BIT 9
`define BS_ABILITIES 16'h7901
`define BS_AN_DONE_BIT 5
`define BS_AN_ABLE_BIT 3
`define BS_LINK_BIT 2
`define PAGE_NP_BIT 15
`define PA_ASYM_BIT 11
`define PA_PAUSE_BIT 10
`define PA_100FD_BIT 8
`define PA_100HD_BIT 7
`define PA_10FD_BIT 6
`define PA_10HD_BIT 5
`define SELECTOR_8023 5'h01
`define EX_PD_FAULT_BIT 4
`define EX_PAGE_RX_BIT 1
`define EX_PARTNER_AN_BIT 0
`define FUNC_ADDR 2'h0
`define FUNC_DATA 2'h1
`define FUNC_INC_RW 2'h2
`define FUNC_INC_WR 2'h3
`define MMD_VENDOR_MMD_DEVICE_SELECT 5'h1f
`define LOCAL_1000FD 1'b1
`define LOCAL_1000HD 1'b1
`define MDIO_OP_READ 2'h2
`define MDIO_OP_WRITE 2'h1
`define MDIO_HDR_LAST 5'h0c
`define MDIO_DATA_LAST 5'h0f
`define MDIO_SKIP_LAST 5'h11
`define BREAK_LINK_DEFAULT 20'h003e8
`endif

// ---- phy_mgmt_pkg.sv ----
// Purpose: Types shared by the PHY management block.
// Assumes: Nothing beyond a SystemVerilog compiler.
// Notes: Constants live in phy_mgmt_defs.svh.
package phy_mgmt_pkg;
  typedef struct packed {
    logic write;
    logic [4:0] reg_addr;
    logic [15:0] data;
  } mgmt_req_s;
  typedef enum logic [1:0] {SPD_10, SPD_100, SPD_1000} speed_e;
  typedef enum logic [2:0] {M_IDLE, M_HDR, M_TA, M_RDATA, M_WDATA, M_SKIP} mdio_state_e;
  typedef enum logic [2:0] {AN_OFF, AN_BREAK, AN_ABILITY, AN_NEXT_PAGE, AN_RESOLVED,
                            AN_GOOD} an_state_e;
endpackage

// ---- phy_mgmt_indirect_autoneg.sv ----
// Purpose: Management registers, indirect extended access and negotiation control of the PHY.
// Assumes: Serial management frames on i_mdc; i_mdc runs while i_sys_rst is held.
// Notes: Read data is published in the system domain well before the data phase samples it.
`include "phy_mgmt_defs.svh"
`timescale 1ns/1ns
`default_nettype none
module phy_mgmt_indirect_autoneg #(
  parameter logic [19:0] BREAK_LINK_CYCLES = `BREAK_LINK_DEFAULT
) (
  input wire logic i_sys_clk,
  input wire logic i_sys_rst,
  input wire logic i_mdc,
  input wire logic i_mdio,
  output logic o_mdio,
  output logic o_mdio_oe,
  input wire logic [4:0] i_phy_addr,
  input wire logic i_strap_an_disable,
  input wire logic i_link_good,
  input wire logic i_pd_link_10,
  input wire logic i_pd_link_100,
  input wire logic [15:0] i_partner_page,
  input wire logic i_partner_page_valid,
  input wire logic i_partner_1000_fd,
  input wire logic i_partner_1000_hd,
  input wire logic i_local_multiport,
  input wire logic i_partner_multiport,
  input wire logic i_tie_master,
  output logic o_clk_out_en,
  output logic o_flp_enable,
  output logic o_tx_silent,
  output logic [15:0] o_tx_page,
  output logic o_an_complete,
  output phy_mgmt_pkg::speed_e o_speed,
  output logic o_full_duplex,
  output logic o_master
);
  import phy_mgmt_pkg::*;

  ////////////////////////////////////////////////////////////////////////////////
  // Management clock domain: serial frame engine
  logic [1:0] mrst_sync_q;
  logic [4:0] paddr_s1_q;
  logic [4:0] paddr_s2_q;
  mdio_state_e mstate_q;
  logic [4:0] mcnt_q;
  logic [15:0] mshift_q;
  mgmt_req_s mreq_q;
  logic mreq_tgl_q;
  logic mdio_q;
  logic mdio_oe_q;
  logic [15:0] rd_word_q;
  wire mrst = mrst_sync_q[1];
  wire [12:0] hdr_w = {mshift_q[11:0], i_mdio};
  wire hdr_ok = hdr_w[12] && (hdr_w[9:5] == paddr_s2_q);
  wire hdr_rd = hdr_w[11:10] == `MDIO_OP_READ;
  wire hdr_wr = hdr_w[11:10] == `MDIO_OP_WRITE;
  wire [15:0] wdata_w = {mshift_q[14:0], i_mdio};

  always_ff @(posedge i_mdc) begin
    mrst_sync_q <= {mrst_sync_q[0], i_sys_rst};
    paddr_s1_q <= i_phy_addr;
    paddr_s2_q <= paddr_s1_q;
  end

  always_ff @(posedge i_mdc) begin
    if (mrst) begin
      mstate_q <= M_IDLE;
      mcnt_q <= 5'h00;
      mshift_q <= 16'h0000;
      mreq_q <= '0;
      mreq_tgl_q <= 1'b0;
      mdio_q <= 1'b0;
      mdio_oe_q <= 1'b0;
    end else begin
      case (mstate_q)
        M_IDLE: begin
          mdio_oe_q <= 1'b0;
          mcnt_q <= 5'h00;
          if (!i_mdio) begin
            mstate_q <= M_HDR;
          end
        end
        M_HDR: begin
          mshift_q <= wdata_w;
          mcnt_q <= mcnt_q + 5'h01;
          if (mcnt_q == `MDIO_HDR_LAST) begin
            mcnt_q <= 5'h00;
            mreq_q.reg_addr <= hdr_w[4:0];
            mreq_q.write <= hdr_wr;
            if (hdr_ok && hdr_rd) begin
              mreq_tgl_q <= ~mreq_tgl_q;
              mstate_q <= M_TA;
            end else if (hdr_ok && hdr_wr) begin
              mstate_q <= M_TA;
            end else begin
              mstate_q <= M_SKIP;
            end
          end
        end
        M_TA: begin
          mcnt_q <= 5'h01;
          if (!mreq_q.write) begin
            mdio_oe_q <= 1'b1;
            mdio_q <= (mcnt_q == 5'h00) ? 1'b0 : rd_word_q[15];
          end
          if (mcnt_q != 5'h00) begin
            mcnt_q <= 5'h00;
            mshift_q <= {rd_word_q[14:0], 1'b0};
            mstate_q <= mreq_q.write ? M_WDATA : M_RDATA;
          end
        end
        M_RDATA: begin
          mdio_q <= mshift_q[15];
          mshift_q <= {mshift_q[14:0], 1'b0};
          mcnt_q <= mcnt_q + 5'h01;
          if (mcnt_q == `MDIO_DATA_LAST) begin
            mdio_oe_q <= 1'b0;
            mstate_q <= M_IDLE;
          end
        end
        M_WDATA: begin
          mshift_q <= wdata_w;
          mcnt_q <= mcnt_q + 5'h01;
          if (mcnt_q == `MDIO_DATA_LAST) begin
            mreq_q.data <= wdata_w;
            mreq_tgl_q <= ~mreq_tgl_q;
            mstate_q <= M_IDLE;
          end
        end
        M_SKIP: begin
          mcnt_q <= mcnt_q + 5'h01;
          if (mcnt_q == `MDIO_SKIP_LAST) begin
            mstate_q <= M_IDLE;
          end
        end
        default: begin
          mstate_q <= M_IDLE;
        end
      endcase
    end
  end

  assign o_mdio = mdio_q;
  assign o_mdio_oe = mdio_oe_q;

  ////////////////////////////////////////////////////////////////////////////////
  // System domain: request crossing and pin synchronisers
  logic rtgl_s1_q;
  logic rtgl_s2_q;
  logic rtgl_s3_q;
  logic [3:0] pin_s1_q;
  logic [3:0] pin_s2_q;
  logic strap_done_q;
  logic strap_dis_q;

  always_ff @(posedge i_sys_clk) begin
    rtgl_s1_q <= mreq_tgl_q;
    rtgl_s2_q <= rtgl_s1_q;
    rtgl_s3_q <= rtgl_s2_q;
    pin_s1_q <= {i_strap_an_disable, i_pd_link_100, i_pd_link_10, i_link_good};
    pin_s2_q <= pin_s1_q;
  end

  wire link_good = pin_s2_q[0];
  wire pd10 = pin_s2_q[1];
  wire pd100 = pin_s2_q[2];
  // Struct is stable for many cycles after its toggle
  wire req_pulse = rtgl_s2_q ^ rtgl_s3_q;
  wire mgmt_req_s req = mreq_q;

  // Strap caught once, first cycle after reset release
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      strap_done_q <= 1'b0;
      strap_dis_q <= 1'b0;
    end else if (!strap_done_q) begin
      strap_done_q <= 1'b1;
      strap_dis_q <= pin_s2_q[3];
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Register decode
  logic [15:0] bc_q;
  logic [15:0] adv_q;
  logic [15:0] partner_q;
  logic [15:0] np_q;
  logic [15:0] ind_ctrl_q;
  logic [15:0] ext_addr_q;
  logic [15:0] clk_cfg_q;
  logic partner_an_q;
  logic page_rx_q;
  logic pd_fault_q;
  an_state_e an_q;
  logic [15:0] mux_rd;

  wire [1:0] ind_func = ind_ctrl_q[15:14];
  wire mmd_device_select_ok = ind_ctrl_q[4:0] == `MMD_VENDOR_MMD_DEVICE_SELECT;
  wire is_ind = req.reg_addr == `REG_IND_DATA;
  wire ind_data = ind_func != `FUNC_ADDR;
  wire ext_is_window = (ext_addr_q == {11'h000, `REG_IND_CTRL}) ||
                       (ext_addr_q == {11'h000, `REG_IND_DATA});
  // Data modes reach the register at the held address
  wire [15:0] eff_addr = is_ind ? ext_addr_q : {11'h000, req.reg_addr};
  wire eff_valid = !is_ind || (mmd_device_select_ok && ind_data && !ext_is_window);
  wire wr_req = req_pulse && req.write;
  wire rd_req = req_pulse && !req.write;
  wire wr_eff = wr_req && eff_valid;
  wire ext_addr_wr = wr_req && is_ind && mmd_device_select_ok && !ind_data;
  wire inc_rw = ind_func == `FUNC_INC_RW;
  wire inc_wr = ind_func == `FUNC_INC_WR;
  // Reads in write-only increment mode keep the address
  wire ext_inc = req_pulse && is_ind && mmd_device_select_ok && (inc_rw || (inc_wr && req.write));
  wire rd_exp = rd_req && eff_valid && (eff_addr == {11'h000, `REG_EXPANSION});
  wire an_en = bc_q[`BC_AN_EN_BIT] && !strap_dis_q;
  wire restart = wr_eff && (eff_addr == {11'h000, `REG_BASIC_CONTROL}) &&
                 req.data[`BC_RESTART_BIT];
  wire an_done = an_q == AN_GOOD;
  wire [15:0] status_w = `BS_ABILITIES | ({15'h0000, !strap_dis_q} << `BS_AN_ABLE_BIT) |
                         ({15'h0000, an_done} << `BS_AN_DONE_BIT) |
                         ({15'h0000, an_done && link_good} << `BS_LINK_BIT);
  // Bit 0 reads 0 after a parallel detect completion
  wire [15:0] exp_w = ({15'h0000, pd_fault_q} << `EX_PD_FAULT_BIT) |
                      ({15'h0000, page_rx_q} << `EX_PAGE_RX_BIT) |
                      {15'h0000, partner_an_q};
  wire [15:0] rd_value = (is_ind && !ind_data) ? (mmd_device_select_ok ? ext_addr_q : 16'h0000) :
                         (eff_valid ? mux_rd : 16'h0000);

  always_comb begin
    mux_rd = 16'h0000;
    case (eff_addr)
      {11'h000, `REG_BASIC_CONTROL}: mux_rd = bc_q;
      {11'h000, `REG_BASIC_STATUS}: mux_rd = status_w;
      {11'h000, `REG_ADVERT}: mux_rd = adv_q;
      {11'h000, `REG_PARTNER}: mux_rd = partner_q;
      {11'h000, `REG_EXPANSION}: mux_rd = exp_w;
      {11'h000, `REG_NP_TX}: mux_rd = np_q;
      {11'h000, `REG_IND_CTRL}: mux_rd = ind_ctrl_q;
      `EXT_CLK_OUT_CFG: mux_rd = clk_cfg_q;
      default: mux_rd = 16'h0000;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Register storage
  wire wr_bc = wr_eff && (eff_addr == {11'h000, `REG_BASIC_CONTROL});
  wire wr_adv = wr_eff && (eff_addr == {11'h000, `REG_ADVERT});
  wire wr_np = wr_eff && (eff_addr == {11'h000, `REG_NP_TX});
  wire wr_ctrl = wr_eff && (eff_addr == {11'h000, `REG_IND_CTRL});
  wire wr_clk = wr_eff && (eff_addr == `EXT_CLK_OUT_CFG);
  // Reset and restart bits do not stay set
  wire [15:0] bc_wmask = ~((16'h0001 << `BC_RESET_BIT) | (16'h0001 << `BC_RESTART_BIT));
  // Wraps naturally at 16 bits
  wire [15:0] ext_addr_d = ext_addr_wr ? req.data :
                           (ext_inc ? ext_addr_q + 16'h0001 : ext_addr_q);

  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      bc_q <= `RST_BASIC_CONTROL;
      adv_q <= `RST_ADVERT;
      np_q <= `RST_NP_TX;
      ind_ctrl_q <= 16'h0000;
      ext_addr_q <= 16'h0000;
      clk_cfg_q <= `RST_CLK_OUT_CFG;
      rd_word_q <= 16'h0000;
    end else begin
      if (wr_bc) bc_q <= req.data & bc_wmask;
      if (wr_adv) adv_q <= req.data;
      if (wr_np) np_q <= req.data;
      if (wr_ctrl) ind_ctrl_q <= req.data;
      if (wr_clk) clk_cfg_q <= req.data;
      if (rd_req) rd_word_q <= rd_value;
      ext_addr_q <= ext_addr_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Negotiation control
  logic [19:0] brk_cnt_q;
  logic pd_mode_q;
  logic flp_q;
  logic silent_q;
  logic [15:0] tx_page_q;
  speed_e speed_q;
  logic fdx_q;
  logic master_q;
  logic done_q;
  logic clk_en_q;
  speed_e hcd_speed;
  logic hcd_fdx;

  wire pd_one = pd10 ^ pd100;
  wire pd_both = pd10 && pd100;
  wire page_in = i_partner_page_valid && ((an_q == AN_ABILITY) || (an_q == AN_NEXT_PAGE));
  wire pd_fault_set = ((an_q == AN_ABILITY) && pd_both && !i_partner_page_valid) ||
                      ((an_q == AN_RESOLVED) && pd_mode_q && !pd10 && !pd100);
  wire page_rx_set = page_in;
  wire g_fd = `LOCAL_1000FD && i_partner_1000_fd && !pd_mode_q;
  wire g_hd = `LOCAL_1000HD && i_partner_1000_hd && !pd_mode_q;
  wire [15:0] common = adv_q & partner_q;
  // Multiport end takes master, tie goes to the tie input
  wire master_w = (i_local_multiport != i_partner_multiport) ? i_local_multiport :
                  i_tie_master;

  // Best shared mode, gigabit first
  always_comb begin
    hcd_speed = SPD_10;
    hcd_fdx = 1'b0;
    if (g_fd) begin
      hcd_speed = SPD_1000;
      hcd_fdx = 1'b1;
    end else if (g_hd) begin
      hcd_speed = SPD_1000;
    end else if (common[`PA_100FD_BIT]) begin
      hcd_speed = SPD_100;
      hcd_fdx = 1'b1;
    end else if (common[`PA_100HD_BIT]) begin
      hcd_speed = SPD_100;
    end else if (common[`PA_10FD_BIT]) begin
      hcd_fdx = 1'b1;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      page_rx_q <= 1'b0;
      pd_fault_q <= 1'b0;
    end else begin
      // A set in the clearing read cycle wins
      page_rx_q <= page_rx_set || (page_rx_q && !rd_exp);
      pd_fault_q <= pd_fault_set || (pd_fault_q && !rd_exp);
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      an_q <= AN_OFF;
      brk_cnt_q <= 20'h00000;
      partner_q <= 16'h0000;
      partner_an_q <= 1'b0;
      pd_mode_q <= 1'b0;
    end else if (!an_en) begin
      an_q <= AN_OFF;
    end else if (restart) begin
      brk_cnt_q <= 20'h00000;
      an_q <= AN_BREAK;
    end else begin
      case (an_q)
        AN_OFF: an_q <= AN_ABILITY;
        AN_BREAK: begin
          brk_cnt_q <= brk_cnt_q + 20'h00001;
          if (brk_cnt_q >= BREAK_LINK_CYCLES - 20'h00001) an_q <= AN_ABILITY;
        end
        AN_ABILITY: begin
          if (i_partner_page_valid) begin
            partner_q <= i_partner_page;
            partner_an_q <= 1'b1;
            pd_mode_q <= 1'b0;
            an_q <= (i_partner_page[`PAGE_NP_BIT] || adv_q[`PAGE_NP_BIT]) ?
                    AN_NEXT_PAGE : AN_RESOLVED;
          end else if (pd_one) begin
            partner_q <= ({15'h0000, pd100} << `PA_100HD_BIT) |
                         ({15'h0000, pd10} << `PA_10HD_BIT) |
                         {11'h000, `SELECTOR_8023};
            partner_an_q <= 1'b0;
            pd_mode_q <= 1'b1;
            an_q <= AN_RESOLVED;
          end
        end
        AN_NEXT_PAGE: begin
          if (i_partner_page_valid && !i_partner_page[`PAGE_NP_BIT] &&
              !np_q[`PAGE_NP_BIT]) begin
            an_q <= AN_RESOLVED;
          end
        end
        AN_RESOLVED: begin
          if (link_good) an_q <= AN_GOOD;
          else if (pd_mode_q && !pd10 && !pd100) an_q <= AN_ABILITY;
        end
        AN_GOOD: begin
          if (!link_good) an_q <= AN_ABILITY;
        end
        default: an_q <= AN_OFF;
      endcase
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      flp_q <= 1'b0;
      silent_q <= 1'b0;
      tx_page_q <= 16'h0000;
      speed_q <= SPD_10;
      fdx_q <= 1'b0;
      master_q <= 1'b0;
      clk_en_q <= 1'b0;
      done_q <= 1'b0;
    end else begin
      flp_q <= (an_q == AN_ABILITY) || (an_q == AN_NEXT_PAGE);
      silent_q <= an_q == AN_BREAK;
      tx_page_q <= (an_q == AN_NEXT_PAGE) ? np_q : adv_q;
      clk_en_q <= !clk_cfg_q[`CLK_OUT_DIS_BIT];
      done_q <= an_done;
      if ((an_q == AN_RESOLVED) && link_good) begin
        speed_q <= hcd_speed;
        fdx_q <= hcd_fdx;
        master_q <= (hcd_speed == SPD_1000) && master_w;
      end
    end
  end

  assign o_clk_out_en = clk_en_q;
  assign o_flp_enable = flp_q;
  assign o_tx_silent = silent_q;
  assign o_tx_page = tx_page_q;
  assign o_an_complete = done_q;
  assign o_speed = speed_q;
  assign o_full_duplex = fdx_q;
  assign o_master = master_q;
endmodule // phy_mgmt_indirect_autoneg
`default_nettype wire

// ---- phy_mgmt_indirect_autoneg_props.sv ----
// Purpose: Checker for negotiation control and the read turnaround
// Assumes: Bound to the top module, sees its ports only
// Notes: Break length is counted in helper logic
`include "phy_mgmt_defs.svh"
`timescale 1ns/1ns
`default_nettype none
module phy_mgmt_indirect_autoneg_props #(
  parameter logic [19:0] BREAK_LINK_CYCLES = `BREAK_LINK_DEFAULT
) (
  input wire logic i_sys_clk,
  input wire logic i_sys_rst,
  input wire logic i_mdc,
  input wire logic o_mdio,
  input wire logic o_mdio_oe,
  input wire logic i_strap_an_disable,
  input wire logic i_link_good,
  input wire logic i_pd_link_10,
  input wire logic i_pd_link_100,
  input wire logic i_partner_1000_fd,
  input wire logic i_local_multiport,
  input wire logic i_partner_multiport,
  input wire logic o_flp_enable,
  input wire logic o_tx_silent,
  input wire logic o_an_complete,
  input var phy_mgmt_pkg::speed_e o_speed,
  input wire logic o_full_duplex,
  input wire logic o_master
);
  import phy_mgmt_pkg::*;
  logic [19:0] sil_q, sil_d;
  logic [3:0] up_q, up_d;
  logic gig_done;
  assign sil_d = o_tx_silent ? sil_q + 20'h1 : 20'h0;
  assign up_d = (up_q == 4'hf) ? up_q : up_q + 4'h1;
  assign gig_done = i_partner_1000_fd && !i_pd_link_10 && !i_pd_link_100;
  always_ff @(posedge i_sys_clk) begin
    sil_q <= i_sys_rst ? 20'h0 : sil_d;
    up_q <= i_sys_rst ? 4'h0 : up_d;
  end
  //////////////////////////////////////////////////////////////
  chk_silent_quiet: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
    o_tx_silent && $past(o_tx_silent) |-> !o_flp_enable && !o_an_complete)
    else $error("pulses during break");
  chk_break_length: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
    $fell(o_tx_silent) |->
      sil_q + 20'h1 >= BREAK_LINK_CYCLES && sil_q <= BREAK_LINK_CYCLES + 20'h1)
    else $error("break length wrong");
  chk_resume_flp: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
    $fell(o_tx_silent) |-> ##[0:2] o_flp_enable)
    else $error("no bursts after break");
  chk_loss_renego: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
    o_an_complete && !i_link_good |-> ##[1:6] !o_an_complete)
    else $error("link loss kept complete");
  chk_master_gig: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
    o_master |-> o_speed == SPD_1000)
    else $error("master without gigabit");
  chk_gig_pick: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
    $rose(o_an_complete) && gig_done |-> ##[0:1] o_speed == SPD_1000 && o_full_duplex)
    else $error("best mode not chosen");
  chk_multiport_wins: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
    $rose(o_an_complete) && gig_done && i_local_multiport && !i_partner_multiport |->
      ##[0:1] o_master)
    else $error("multiport not master");
  chk_strap_block: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
    i_strap_an_disable && up_q == 4'hf |-> !o_flp_enable && !o_tx_silent)
    else $error("strap disable ignored");
  chk_turnaround_zero: assert property (@(posedge i_mdc) disable iff (i_sys_rst)
    $rose(o_mdio_oe) |-> !o_mdio ##1 o_mdio_oe [*8])
    else $error("read turnaround wrong");
  cov_gig: cover property (@(posedge i_sys_clk) o_an_complete && o_speed == SPD_1000);
  cov_break: cover property (@(posedge i_sys_clk) $fell(o_tx_silent));
  cov_read: cover property (@(posedge i_mdc) $rose(o_mdio_oe));
endmodule // phy_mgmt_indirect_autoneg_props
bind phy_mgmt_indirect_autoneg phy_mgmt_indirect_autoneg_props #(
  .BREAK_LINK_CYCLES(BREAK_LINK_CYCLES)
) u_props (.*);
`default_nettype wire

// ---- mdio_station_model.sv ----
// Purpose: Station model issuing management frames
// Assumes: Management clock only runs during frames and idle bits
// Notes: Released data line pulls up to 1
`timescale 1ns/1ns
`default_nettype none
module mdio_station_model (
  output logic o_mdc,
  output logic o_mdio,
  input wire logic i_dev_mdio,
  input wire logic i_dev_oe
);
  logic drv = 1'b0;
  logic val = 1'b0;
  initial o_mdc = 1'b0;
  assign o_mdio = i_dev_oe ? i_dev_mdio : (drv ? val : 1'b1);
  task automatic bit_out(input logic en, input logic b);
    drv = en;
    val = b;
    #16 o_mdc = 1'b1;
    #16 o_mdc = 1'b0;
  endtask
  task automatic idle(input int n);
    repeat (n) bit_out(1'b0, 1'b0);
  endtask
  task automatic xfer(input logic wr, input logic [4:0] ra, input logic [15:0] wd,
                      output logic [15:0] rd);
    logic [31:0] f;
    f = {2'b01, !wr, wr, 5'h01, ra, wr, 1'b0, wd};
    rd = 16'h0;
    idle(2);
    for (int i = 31; i >= 0; i--) begin
      bit_out(wr || i > 17, f[i]);
      if (i >= 1 && i <= 16) rd = {rd[14:0], o_mdio};
    end
    idle(2);
  endtask
endmodule // mdio_station_model
`default_nettype wire

// ---- phy_mgmt_indirect_autoneg_tb.sv ----
// Purpose: Self-checking bench for the PHY management block
// Assumes: Short break count, station model on the management pins
// Notes: Inputs change 1 ns after the system clock edge
`include "phy_mgmt_defs.svh"
`timescale 1ns/1ns
`default_nettype none
module phy_mgmt_indirect_autoneg_tb;
  import phy_mgmt_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic strap = 1'b0;
  logic link = 1'b0;
  logic pd10 = 1'b0;
  logic pd100 = 1'b0;
  logic pg_v = 1'b0;
  logic lmp = 1'b1;
  logic p_fd = 1'b1;
  logic p_hd = 1'b0;
  logic pmp = 1'b0;
  logic tie = 1'b0;
  logic [15:0] pg = 16'h0;
  logic mdc, mdio, dout, oe, clk_en, flp, silent, done, mst, fdx;
  logic [15:0] tx_pg;
  speed_e spd;
  int miscompares = 0;
  int n_compared = 0;
  phy_mgmt_indirect_autoneg #(.BREAK_LINK_CYCLES(20'h8)) dut (
    .i_sys_clk(clk), .i_sys_rst(rst), .i_mdc(mdc), .i_mdio(mdio), .o_mdio(dout),
    .o_mdio_oe(oe), .i_phy_addr(5'h01), .i_strap_an_disable(strap), .i_link_good(link),
    .i_pd_link_10(pd10), .i_pd_link_100(pd100), .i_partner_page(pg),
    .i_partner_page_valid(pg_v), .i_partner_1000_fd(p_fd), .i_partner_1000_hd(p_hd),
    .i_local_multiport(lmp), .i_partner_multiport(pmp), .i_tie_master(tie),
    .o_clk_out_en(clk_en), .o_flp_enable(flp), .o_tx_silent(silent), .o_tx_page(tx_pg),
    .o_an_complete(done), .o_speed(spd), .o_full_duplex(fdx), .o_master(mst));
  mdio_station_model m (.o_mdc(mdc), .o_mdio(mdio), .i_dev_mdio(dout), .i_dev_oe(oe));
  initial forever #2 clk = ~clk;
  //////////////////////////////////////////////////////////////
  task automatic give_verdict;
    $display("compared %0d miscompares %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_compared++;
    if (g !== e) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic tick;
    @(posedge clk);
    #1;
  endtask
  task automatic wr(input logic [4:0] ra, input logic [15:0] d);
    logic [15:0] x;
    m.xfer(1'b1, ra, d, x);
  endtask
  task automatic rd(input logic [4:0] ra, input logic [15:0] msk, input logic [15:0] e);
    logic [15:0] x;
    m.xfer(1'b0, ra, 16'h0, x);
    chk($sformatf("reg %h", ra), e & msk, x & msk);
  endtask
  function automatic logic probe(input int k);
    return k == 0 ? done : (k == 1 ? flp : silent);
  endfunction
  task automatic wait_sig(input int k, input logic v);
    int n;
    n = 0;
    while (probe(k) !== v && n < 400) begin
      tick();
      n++;
    end
    chk($sformatf("signal %0d", k), {15'h0, v}, {15'h0, probe(k)});
    if (n >= 400) give_verdict();
  endtask
  task automatic page(input logic [15:0] p);
    tick();
    pg = p;
    pg_v = 1'b1;
    tick();
    pg_v = 1'b0;
  endtask
  task automatic do_reset(input logic s);
    tick();
    rst = 1'b1;
    strap = s;
    fork
      repeat (12) @(posedge clk);
      m.idle(4);
    join
    tick();
    rst = 1'b0;
    m.idle(2);
  endtask
  //////////////////////////////////////////////////////////////
  task automatic t_indirect;
    rd(5'h00, 16'hffff, `RST_BASIC_CONTROL);
    chk("clk out", 16'h1, {15'h0, clk_en});
    wr(5'h0d, 16'h001f);
    wr(5'h0e, `EXT_CLK_OUT_CFG);
    wr(5'h0d, 16'h401f);
    rd(5'h0e, 16'hffff, `RST_CLK_OUT_CFG);
    rd(5'h0e, 16'hffff, `RST_CLK_OUT_CFG);
    wr(5'h0e, 16'h0c50);
    chk("clk out", 16'h0, {15'h0, clk_en});
    wr(5'h0d, 16'h401e);
    rd(5'h0e, 16'hffff, 16'h0);
    wr(5'h0e, 16'h0c10);
    wr(5'h0d, 16'h401f);
    rd(5'h0e, 16'hffff, 16'h0c50);
    wr(5'h0e, 16'h0c10);
    chk("clk out", 16'h1, {15'h0, clk_en});
  endtask
  task automatic t_incr;
    wr(5'h0d, 16'h001f);
    wr(5'h0e, 16'h0003);
    wr(5'h0d, 16'h801f);
    rd(5'h0e, 16'hffff, 16'h0);
    rd(5'h0e, 16'hffff, `RST_ADVERT);
    wr(5'h0d, 16'h001f);
    rd(5'h0e, 16'hffff, 16'h0005);
    wr(5'h0e, 16'h0007);
    wr(5'h0d, 16'hc01f);
    rd(5'h0e, 16'hffff, `RST_NP_TX);
    rd(5'h0e, 16'hffff, `RST_NP_TX);
    wr(5'h0e, 16'h2002);
    wr(5'h0e, 16'h1234);
    wr(5'h0d, 16'h001f);
    rd(5'h0e, 16'hffff, 16'h0009);
    rd(5'h07, 16'hffff, 16'h2002);
    wr(5'h0e, 16'hffff);
    wr(5'h0d, 16'hc01f);
    wr(5'h0e, 16'h0);
    wr(5'h0d, 16'h001f);
    rd(5'h0e, 16'hffff, 16'h0);
  endtask
  task automatic t_neg;
    wr(5'h04, 16'h0de1);
    wr(5'h07, 16'h0123);
    chk("tx page", 16'h0de1, tx_pg);
    page(16'h8c21);
    rd(5'h05, 16'hffff, 16'h8c21);
    chk("tx page", 16'h0123, tx_pg);
    page(16'h0001);
    link = 1'b1;
    wait_sig(0, 1'b1);
    chk("speed", {14'h0, SPD_1000}, {14'h0, spd});
    chk("master", 16'h1, {15'h0, mst});
    chk("duplex", 16'h1, {15'h0, fdx});
    rd(5'h01, 16'hffff, 16'h792d);
    tick();
    link = 1'b0;
    wait_sig(0, 1'b0);
    wait_sig(1, 1'b1);
    p_fd = 1'b0;
    p_hd = 1'b1;
    pmp = 1'b1;
    tie = 1'b1;
    link = 1'b1;
    page(16'h0c21);
    wait_sig(0, 1'b1);
    chk("speed", {14'h0, SPD_1000}, {14'h0, spd});
    chk("duplex", 16'h0, {15'h0, fdx});
    chk("master", 16'h1, {15'h0, mst});
    fork
      wr(5'h00, 16'h1340);
      wait_sig(2, 1'b1);
    join
    wait_sig(1, 1'b1);
    lmp = 1'b0;
    page(16'h0c21);
    wait_sig(0, 1'b1);
    chk("master", 16'h0, {15'h0, mst});
    rd(5'h00, 16'hffff, `RST_BASIC_CONTROL);
  endtask
  task automatic t_pd;
    tick();
    link = 1'b0;
    pd100 = 1'b1;
    repeat (20) tick();
    link = 1'b1;
    wait_sig(0, 1'b1);
    chk("speed", {14'h0, SPD_100}, {14'h0, spd});
    rd(5'h05, 16'hffff, 16'h0081);
    rd(5'h06, 16'h0001, 16'h0);
    tick();
    pd100 = 1'b0;
    link = 1'b0;
    wait_sig(1, 1'b1);
    pd10 = 1'b1;
    pd100 = 1'b1;
    repeat (20) tick();
    rd(5'h06, 16'h0010, 16'h0010);
    tick();
    pd10 = 1'b0;
    pd100 = 1'b0;
  endtask
  task automatic t_dis;
    wr(5'h00, 16'h0140);
    wait_sig(1, 1'b0);
    wr(5'h00, 16'h1140);
    wait_sig(1, 1'b1);
    do_reset(1'b1);
    wr(5'h00, 16'h1340);
    chk("bursts", 16'h0, {15'h0, flp});
    rd(5'h01, 16'h0008, 16'h0);
  endtask
  initial begin
    do_reset(1'b0);
    wait_sig(1, 1'b1);
    t_indirect();
    t_incr();
    t_neg();
    t_pd();
    t_dis();
    give_verdict();
  end
endmodule // phy_mgmt_indirect_autoneg_tb
`default_nettype wire
